// *** rtl/can_flt_pkg.sv ***
// Overview of operation
// - Transmit error count of 256 sets bus-off and reset request; node leaves bus.
// - After reset request clears, 128 runs of 11 recessive bits end bus-off.
// - Error warning is set while either error counter is at 96 or more.
// - Transmit active sets when sending starts; both activity bits clear means idle.
// - Receive active sets on frame reception from idle or on lost arbitration.
// - Transmit request clears complete flag; only successful sending or reset request sets it again.
// - Abort before sending starts frees the buffer and keeps complete flag clear.
// - Pending or sending message locks transmit buffer; writes then vanish silently.
// - Message with both receive buffers full sets overrun and is dropped quietly.
// - Clear-overrun command bit clears the overrun flag.
// - Own outgoing frame is held in a receive buffer and may cause overrun.
// - Receive-full sets on new message, clears on release unless second buffer waits.
// - Event flags are read-only; a read clears only the flags it returned.
// - Bus activity while asleep clears sleep and sets the wake flag.
// - Overrun with its enable sets overrun event; cleared by read or reset request.
// - Bus-off or warning change with its enable sets error event; read clears.
// - Transmission end with buffer free and enable sets transmit event.
// - New message with receive enable sets receive event together with receive-full.
// - Acceptance code is compared with identifier bits 10 to 3, then masked.
// - Clear mask bits must match; set mask bits are ignored for acceptance.
// - Every frame lands in the fill buffer while that buffer is free; rejected ones are simply overwritten.
// - Accepted frame goes to a free buffer, else overrun is signalled.
// - Reset request aborts current transfer and enters reset state; only CPU clears it.
// - Release command hands the CPU buffer back and may expose a waiting message.
package can_flt_pkg;
    // Register indices; the bus byte address is four times the index.
    localparam logic [7:0] IDX_CONTROL  = 8'h20;
    localparam logic [7:0] IDX_COMMAND  = 8'h21;
    localparam logic [7:0] IDX_STATUS   = 8'h22;
    localparam logic [7:0] IDX_EVENTS   = 8'h23;
    localparam logic [7:0] IDX_ACC_CODE = 8'h24;
    localparam logic [7:0] IDX_ACC_MASK = 8'h25;
    localparam logic [7:0] IDX_TXBUF    = 8'h30;
    localparam logic [7:0] IDX_RXBUF    = 8'h40;
    localparam logic [7:0] FRAME_N      = 8'h0a;
    localparam int         FRAME_BYTES  = 10;

    localparam logic [8:0] TEC_BUS_OFF  = 9'h100;
    localparam logic [8:0] WARN_LIMIT   = 9'h060;
    localparam logic [7:0] RECOVER_SEQS = 8'h80;
    localparam logic [7:0] RECOVER_LAST = RECOVER_SEQS - 8'h01;

    localparam int CTL_RR    = 0;
    localparam logic [7:0] CTL_EN_MASK = 8'h1e;
    localparam int CTL_RIE   = 1;
    localparam int CTL_TIE   = 2;
    localparam int CTL_EIE   = 3;
    localparam int CTL_OIE   = 4;
    localparam int CMD_TR    = 0;
    localparam int CMD_AT    = 1;
    localparam int CMD_RRB   = 2;
    localparam int CMD_COS   = 3;
    localparam int CMD_SLEEP = 4;
    localparam logic [7:0] CMD_READ = 8'hff;
    localparam int EV_RX     = 0;
    localparam int EV_TX     = 1;
    localparam int EV_ERR    = 2;
    localparam int EV_OVR    = 3;
    localparam int EV_WAKE   = 4;

    typedef struct packed {
        logic tx_start;
        logic tx_ok;
        logic arb_lost;
        logic rx_start;
        logic frame_end;
        logic rx_ok;
        logic rec11;
    } proto_evt_s;

    typedef struct packed {
        logic       wr;
        logic [3:0] idx;
        logic [7:0] data;
    } rx_byte_s;
endpackage

// *** rtl/can_status_irq_accept_filter.sv ***
// Register access over APB was left to the implementer.
module can_status_irq_accept_filter (
    input  logic                    i_clk,
    input  logic                    i_rst,
    input  logic [11:0]             i_paddr,
    input  logic                    i_psel,
    input  logic                    i_penable,
    input  logic                    i_pwrite,
    input  logic [31:0]             i_pwdata,
    input  logic [3:0]              i_pstrb,
    output logic                    o_pready,
    output logic [31:0]             o_prdata,
    output logic                    o_pslverr,
    input  can_flt_pkg::proto_evt_s i_evt,
    input  can_flt_pkg::rx_byte_s   i_rx_byte,
    input  logic [8:0]              i_tx_err_cnt,
    input  logic [8:0]              i_rx_err_cnt,
    input  logic                    i_can_rx,
    input  logic [3:0]              i_tx_idx,
    output logic [7:0]              o_tx_byte,
    output logic                    o_tx_request,
    output logic                    o_reset_request,
    output logic                    o_bus_off,
    output logic                    o_bus_enable,
    output logic                    o_sleep,
    output logic                    o_err_cnt_clear
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic in_buf(input logic [7:0] a, input logic [7:0] base);
        return (a >= base) && (a < base + can_flt_pkg::FRAME_N);
    endfunction

    function automatic logic [3:0] buf_off(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        return d[3:0];
    endfunction

    function automatic logic accepted(input logic [7:0] id_hi, input logic [7:0] code,
                                      input logic [7:0] mask);
        return &(mask | ~(id_hi ^ code));
    endfunction

    logic [7:0] idx;
    logic       done;
    logic       wr_ok;
    logic [7:0] wd;
    logic [7:0] ctl_en;
    logic [7:0] accept_code;
    logic [7:0] accept_mask;
    logic [7:0] tx_mem [can_flt_pkg::FRAME_BYTES];
    logic [7:0] rx_mem [2][can_flt_pkg::FRAME_BYTES];
    logic [1:0] full;
    logic       cpu_sel;
    logic       rx_buffer_full;
    logic       data_overrun;
    logic       tx_active;
    logic       rx_active;
    logic       tx_complete_flag;
    logic       error_warning_flag;
    logic       bs_prev;
    logic       es_prev;
    logic [7:0] recover_cnt;
    logic [4:0] evf;
    logic       rx_meta;
    logic       rx_sync;
    logic [7:0] rd;
    logic       hit;
    logic       cmd_wr;
    logic       tr_cmd;
    logic       abort_ok;
    logic       frame_in;
    logic       accept_now;
    logic       commit;
    logic       ovr;
    logic       release_cmd;
    logic [1:0] next_full;
    logic       next_sel;
    logic       wake_evt;
    logic       bus_off_set;
    logic       recover_done;
    logic [4:0] ev_set;
    logic [4:0] ev_clr;

    assign idx    = i_paddr[9:2];
    assign done   = i_psel & i_penable & o_pready;
    assign wr_ok  = done & i_pwrite & i_pstrb[0];
    assign wd     = i_pwdata[7:0];
    assign cmd_wr = wr_ok & (idx == can_flt_pkg::IDX_COMMAND) & ~o_reset_request;
    assign tr_cmd = cmd_wr & wd[can_flt_pkg::CMD_TR] & ~o_tx_request;
    assign abort_ok = cmd_wr & wd[can_flt_pkg::CMD_AT] & o_tx_request & ~tx_active;
    assign release_cmd = cmd_wr & wd[can_flt_pkg::CMD_RRB];

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_comb
    begin
        rd  = 8'h00;
        hit = 1'b1;
        case (idx)
            can_flt_pkg::IDX_CONTROL:  rd = ctl_en | {7'h00, o_reset_request};
            can_flt_pkg::IDX_COMMAND:  rd = can_flt_pkg::CMD_READ;
            // Status is only ever read here; no write path exists.
            can_flt_pkg::IDX_STATUS:   rd = {o_bus_off, error_warning_flag, tx_active, rx_active,
                                             tx_complete_flag, ~o_tx_request, data_overrun,
                                             rx_buffer_full};
            can_flt_pkg::IDX_EVENTS:   rd = {3'h0, evf};
            can_flt_pkg::IDX_ACC_CODE: rd = accept_code;
            can_flt_pkg::IDX_ACC_MASK: rd = accept_mask;
            default:
            begin
                if (in_buf(idx, can_flt_pkg::IDX_TXBUF))
                    rd = tx_mem[buf_off(idx, can_flt_pkg::IDX_TXBUF)];
                else if (in_buf(idx, can_flt_pkg::IDX_RXBUF))
                    rd = rx_mem[cpu_sel][buf_off(idx, can_flt_pkg::IDX_RXBUF)];
                else
                    hit = 1'b0;
            end
        endcase
    end

    // Read data is captured in the setup cycle so the answer comes from a flop.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else if (i_psel & ~i_penable)
        begin
            o_pready  <= 1'b1;
            o_prdata  <= {24'h00_0000, rd};
            o_pslverr <= ~hit;
        end
        else
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control, filter and transmit buffer registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_reset_request <= 1'b1;
        else if (bus_off_set)
            o_reset_request <= 1'b1;
        else if (wr_ok && idx == can_flt_pkg::IDX_CONTROL)
            o_reset_request <= wd[can_flt_pkg::CTL_RR];
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ctl_en      <= 8'h00;
            accept_code <= 8'h00;
            accept_mask <= 8'h00;
        end
        else if (wr_ok)
        begin
            if (idx == can_flt_pkg::IDX_CONTROL)
                ctl_en <= wd & can_flt_pkg::CTL_EN_MASK;
            // Filter writes outside reset state are dropped so a live match never glitches.
            if (idx == can_flt_pkg::IDX_ACC_CODE && o_reset_request)
                accept_code <= wd;
            if (idx == can_flt_pkg::IDX_ACC_MASK && o_reset_request)
                accept_mask <= wd;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (wr_ok && ~o_tx_request && in_buf(idx, can_flt_pkg::IDX_TXBUF))
            tx_mem[buf_off(idx, can_flt_pkg::IDX_TXBUF)] <= wd;
        o_tx_byte <= (i_rst || i_tx_idx >= can_flt_pkg::FRAME_N[3:0]) ? 8'h00 : tx_mem[i_tx_idx];
    end

    // ------------------------------------------------------------
    // Transmit and activity status
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst || o_reset_request)
        begin
            o_tx_request     <= 1'b0;
            tx_complete_flag <= 1'b1;
            tx_active        <= 1'b0;
            rx_active        <= 1'b0;
        end
        else
        begin
            if (tr_cmd)
            begin
                o_tx_request     <= 1'b1;
                tx_complete_flag <= 1'b0;
            end
            else if (i_evt.tx_ok)
            begin
                o_tx_request     <= 1'b0;
                tx_complete_flag <= 1'b1;
            end
            else if (abort_ok)
                o_tx_request <= 1'b0;
            if (i_evt.tx_start)
                tx_active <= 1'b1;
            else if (i_evt.tx_ok || i_evt.arb_lost || i_evt.frame_end)
                tx_active <= 1'b0;
            if (i_evt.rx_start || i_evt.arb_lost)
                rx_active <= 1'b1;
            else if (i_evt.frame_end)
                rx_active <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus-off, recovery and error warning
    // ------------------------------------------------------------
    assign bus_off_set  = (i_tx_err_cnt >= can_flt_pkg::TEC_BUS_OFF) & ~o_bus_off
                          & ~o_err_cnt_clear;
    assign recover_done = o_bus_off & ~o_reset_request & i_evt.rec11
                          & (recover_cnt == can_flt_pkg::RECOVER_LAST);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_bus_off          <= 1'b0;
            recover_cnt        <= 8'h00;
            o_err_cnt_clear    <= 1'b0;
            error_warning_flag <= 1'b0;
            bs_prev            <= 1'b0;
            es_prev            <= 1'b0;
            o_bus_enable       <= 1'b0;
        end
        else
        begin
            if (bus_off_set)
                o_bus_off <= 1'b1;
            else if (recover_done)
                o_bus_off <= 1'b0;
            // Counting only starts once software has let go of the reset request.
            if (~o_bus_off || o_reset_request || recover_done)
                recover_cnt <= 8'h00;
            else if (i_evt.rec11)
                recover_cnt <= recover_cnt + 8'h01;
            o_err_cnt_clear    <= recover_done;
            error_warning_flag <= (i_rx_err_cnt >= can_flt_pkg::WARN_LIMIT)
                                | (i_tx_err_cnt >= can_flt_pkg::WARN_LIMIT);
            bs_prev            <= o_bus_off;
            es_prev            <= error_warning_flag;
            o_bus_enable       <= ~o_reset_request & ~o_bus_off & ~bus_off_set;
        end
    end

    // ------------------------------------------------------------
    // Receive buffers, filter and overrun
    // ------------------------------------------------------------
    assign frame_in   = i_evt.frame_end & i_evt.rx_ok & rx_active & ~o_reset_request;
    assign accept_now = accepted(rx_mem[~cpu_sel][0], accept_code, accept_mask);
    assign ovr        = frame_in & accept_now & full[~cpu_sel];
    assign commit     = frame_in & accept_now & ~full[~cpu_sel];

    always_comb
    begin
        next_full = full;
        next_sel  = cpu_sel;
        if (release_cmd)
        begin
            next_full[cpu_sel] = 1'b0;
            if (full[~cpu_sel])
                next_sel = ~cpu_sel;
        end
        if (commit)
        begin
            next_full[~cpu_sel] = 1'b1;
            if (!next_full[next_sel])
                next_sel = ~cpu_sel;
        end
    end

    // Own outgoing frames are written here too, so a transmit may fill a buffer.
    always_ff @(posedge i_clk)
    begin
        if (i_rx_byte.wr && !full[~cpu_sel] && i_rx_byte.idx < can_flt_pkg::FRAME_N[3:0])
            rx_mem[~cpu_sel][i_rx_byte.idx] <= i_rx_byte.data;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst || o_reset_request)
        begin
            full           <= 2'b00;
            cpu_sel        <= 1'b0;
            rx_buffer_full <= 1'b0;
            data_overrun   <= 1'b0;
        end
        else
        begin
            full           <= next_full;
            cpu_sel        <= next_sel;
            rx_buffer_full <= next_full[next_sel];
            data_overrun   <= ovr | (data_overrun & ~(cmd_wr & wd[can_flt_pkg::CMD_COS]));
        end
    end

    // ------------------------------------------------------------
    // Sleep, wake and event flags
    // ------------------------------------------------------------
    assign wake_evt = o_sleep & (~rx_sync | tx_active | rx_active);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            o_sleep <= 1'b0;
        end
        else
        begin
            rx_meta <= i_can_rx;
            rx_sync <= rx_meta;
            if (wake_evt)
                o_sleep <= 1'b0;
            else if (cmd_wr)
                o_sleep <= wd[can_flt_pkg::CMD_SLEEP];
        end
    end

    always_comb
    begin
        ev_set = 5'h00;
        ev_set[can_flt_pkg::EV_WAKE] = wake_evt;
        ev_set[can_flt_pkg::EV_OVR]  = ovr & ctl_en[can_flt_pkg::CTL_OIE];
        ev_set[can_flt_pkg::EV_ERR]  = ((o_bus_off ^ bs_prev) | (error_warning_flag ^ es_prev))
                                       & ctl_en[can_flt_pkg::CTL_EIE];
        ev_set[can_flt_pkg::EV_TX]   = (i_evt.tx_ok | abort_ok) & ~o_reset_request
                                       & ctl_en[can_flt_pkg::CTL_TIE];
        ev_set[can_flt_pkg::EV_RX]   = commit & ctl_en[can_flt_pkg::CTL_RIE];
        // Only the bits the software actually saw are cleared, so a late event survives.
        ev_clr = (done && !i_pwrite && idx == can_flt_pkg::IDX_EVENTS) ? o_prdata[4:0] : 5'h00;
        if (o_reset_request)
        begin
            ev_clr[can_flt_pkg::EV_OVR] = 1'b1;
            ev_clr[can_flt_pkg::EV_TX]  = 1'b1;
            ev_clr[can_flt_pkg::EV_RX]  = 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            evf <= 5'h00;
        else
            evf <= ev_set | (evf & ~ev_clr);
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_bus_off_entry: assert property (@(posedge i_clk) disable iff (i_rst)
        bus_off_set |=> o_bus_off && o_reset_request ##1 !o_bus_enable)
        else $error("bus-off entry did not set flags");
    a_recover_exit: assert property (@(posedge i_clk) disable iff (i_rst)
        recover_done |=> !o_bus_off && o_err_cnt_clear ##1 !o_err_cnt_clear)
        else $error("bus-off recovery exit wrong");
    a_warn_level: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_tx_err_cnt < can_flt_pkg::WARN_LIMIT && i_rx_err_cnt < can_flt_pkg::WARN_LIMIT) [*2]
        |-> !error_warning_flag)
        else $error("warning flag set below limit");
    a_tr_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        tr_cmd && !o_reset_request |=> !tx_complete_flag && o_tx_request)
        else $error("transmit request did not clear complete");
    a_abort_frees: assert property (@(posedge i_clk) disable iff (i_rst)
        abort_ok && !i_evt.tx_ok && !o_reset_request |=> !o_tx_request && !tx_complete_flag)
        else $error("abort did not free buffer");
    a_overrun_set: assert property (@(posedge i_clk) disable iff (i_rst)
        ovr && !o_reset_request |=> data_overrun && $stable(full))
        else $error("overrun not flagged or buffer changed");
    a_read_clears: assert property (@(posedge i_clk) disable iff (i_rst)
        done && !i_pwrite && idx == can_flt_pkg::IDX_EVENTS && ev_set == 5'h00
        |=> (evf & $past(o_prdata[4:0])) == 5'h00)
        else $error("event read did not clear flags");
    a_rx_event: assert property (@(posedge i_clk) disable iff (i_rst)
        commit && ctl_en[can_flt_pkg::CTL_RIE] |=> evf[can_flt_pkg::EV_RX] && rx_buffer_full)
        else $error("receive event or full flag missing");
    a_filter_reject: assert property (@(posedge i_clk) disable iff (i_rst)
        frame_in && !accepted(rx_mem[~cpu_sel][0], accept_code, accept_mask)
        |=> $past(full) == full || $past(release_cmd))
        else $error("rejected frame was stored");
endmodule

// *** dv/can_node_model.sv ***
module can_node_model (
    input  logic                    i_clk,
    input  logic                    i_err_cnt_clear,
    output can_flt_pkg::proto_evt_s o_evt,
    output can_flt_pkg::rx_byte_s   o_rx_byte,
    output logic [8:0]              o_tx_err_cnt,
    output logic                    o_can_rx
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Far-side protocol activity
    // ----------------------------------------
    // The bus idles recessive; released byte lines show the inverse of the last value.
    initial
    begin
        o_evt = '0;
        o_rx_byte = '0;
        o_tx_err_cnt = '0;
        o_can_rx = 1'b1;
    end
    always @(posedge i_clk)
        if (i_err_cnt_clear)
            o_tx_err_cnt <= '0;
    task automatic pulse(input logic [6:0] v);
        @(posedge i_clk);
        o_evt <= v;
        @(posedge i_clk);
        o_evt <= '0;
    endtask
    task automatic rec(input int n);
        repeat (n) pulse(7'h01);
    endtask
    task automatic set_tec(input logic [8:0] v);
        @(posedge i_clk);
        o_tx_err_cnt <= v;
    endtask
    task automatic frame(input logic [7:0] id);
        @(posedge i_clk);
        o_can_rx <= 1'b0;
        o_evt <= 7'h08;
        for (int i = 0; i < 10; i++)
        begin
            @(posedge i_clk);
            o_evt <= '0;
            o_rx_byte <= {1'b1, 4'(i), (i == 0) ? id : 8'(i)};
        end
        @(posedge i_clk);
        o_rx_byte <= {1'b0, 4'h0, ~o_rx_byte.data};
        o_evt <= 7'h06;
        @(posedge i_clk);
        o_evt <= '0;
        o_can_rx <= 1'b1;
    endtask
endmodule

// *** dv/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CT = can_flt_pkg::IDX_CONTROL;
    localparam logic [7:0] CM = can_flt_pkg::IDX_COMMAND;
    localparam logic [7:0] ST = can_flt_pkg::IDX_STATUS;
    localparam logic [7:0] EV = can_flt_pkg::IDX_EVENTS;
    localparam logic [7:0] AC = can_flt_pkg::IDX_ACC_CODE;
    localparam logic [7:0] AM = can_flt_pkg::IDX_ACC_MASK;
    localparam logic [7:0] TB = can_flt_pkg::IDX_TXBUF;
    localparam logic [7:0] RB = can_flt_pkg::IDX_RXBUF;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] paddr = '0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [3:0]  pstrb = 4'hf;
    logic [3:0]  txidx = 4'h0;
    logic [8:0]  rx_ecnt = 9'h000;
    logic [31:0] prdata;
    logic        pready, pslverr, txr, rr, boff, ben, slp, eclr, can_rx, err;
    logic [7:0]  txb, rd;
    logic [8:0]  tec;
    can_flt_pkg::proto_evt_s evt;
    can_flt_pkg::rx_byte_s   rxb;
    int          fails = 0;
    int          check_count = 0;

    can_status_irq_accept_filter u_dut (.i_clk(clk), .i_rst(rst), .i_paddr(paddr),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_evt(evt), .i_rx_byte(rxb), .i_tx_err_cnt(tec), .i_rx_err_cnt(rx_ecnt),
        .i_can_rx(can_rx), .i_tx_idx(txidx), .o_tx_byte(txb), .o_tx_request(txr),
        .o_reset_request(rr), .o_bus_off(boff), .o_bus_enable(ben), .o_sleep(slp),
        .o_err_cnt_clear(eclr));
    can_node_model u_node (.i_clk(clk), .i_err_cnt_clear(eclr), .o_evt(evt),
        .o_rx_byte(rxb), .o_tx_err_cnt(tec), .o_can_rx(can_rx));

    // ----------------------------------------
    // Bus access and comparison
    // ----------------------------------------
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // The wait is counted so a slave that never answers cannot hang the run.
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
            chk(8'h00, 8'h01);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rdc(ST, 8'h0c);
        rdc(EV, 8'h00);
        apb(1'b1, ST, 8'hff);
        rdc(ST, 8'h0c);
        apb(1'b0, 8'h50, 8'h00);
        chk({7'h0, err}, 8'h01);
        pstrb <= 4'he;
        apb(1'b1, AC, 8'h3c);
        pstrb <= 4'hf;
        rdc(AC, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_filter;
        apb(1'b1, AC, 8'ha5);
        apb(1'b1, AM, 8'h0f);
        rdc(AC, 8'ha5);
        apb(1'b1, CT, 8'h1e);
        u_node.rec(1);
        u_node.frame(8'h25);
        rdc(ST, 8'h0c);
        u_node.frame(8'ha3);
        rdc(ST, 8'h0d);
        rdc(EV, 8'h01);
        rdc(EV, 8'h00);
        rdc(RB, 8'ha3);
        $display("filter test done");
    endtask
    task automatic t_overrun;
        u_node.frame(8'ha7);
        rdc(EV, 8'h01);
        u_node.frame(8'haa);
        rdc(ST, 8'h0f);
        rdc(EV, 8'h08);
        apb(1'b1, CM, 8'h08);
        rdc(ST, 8'h0d);
        apb(1'b1, CM, 8'h04);
        rdc(ST, 8'h0d);
        rdc(RB, 8'ha7);
        apb(1'b1, CM, 8'h04);
        rdc(ST, 8'h0c);
        $display("overrun test done");
    endtask
    task automatic t_tx;
        apb(1'b1, TB, 8'h11);
        apb(1'b1, CM, 8'h01);
        rdc(ST, 8'h00);
        apb(1'b1, TB, 8'h22);
        @(negedge clk);
        chk(txb, 8'h11);
        @(posedge clk);
        txidx <= 4'ha;
        repeat (2) @(negedge clk);
        chk(txb, 8'h00);
        @(posedge clk);
        txidx <= 4'h0;
        apb(1'b1, CM, 8'h02);
        rdc(ST, 8'h04);
        rdc(EV, 8'h02);
        apb(1'b1, CM, 8'h01);
        u_node.pulse(7'h40);
        rdc(ST, 8'h20);
        u_node.pulse(7'h20);
        rdc(ST, 8'h0c);
        rdc(EV, 8'h02);
        $display("transmit test done");
    endtask
    task automatic t_busoff;
        rx_ecnt <= 9'h060;
        rdc(ST, 8'h4c);
        rx_ecnt <= 9'h05f;
        rdc(ST, 8'h0c);
        rdc(EV, 8'h04);
        u_node.set_tec(9'h060);
        rdc(ST, 8'h4c);
        rdc(EV, 8'h04);
        u_node.set_tec(9'h100);
        repeat (3) @(negedge clk);
        chk({5'h0, ben, boff, rr}, 8'h03);
        rdc(ST, 8'hcc);
        apb(1'b1, CT, 8'h1e);
        u_node.rec(127);
        chk({7'h0, boff}, 8'h01);
        u_node.rec(1);
        repeat (2) @(negedge clk);
        chk({6'h0, boff, ben}, 8'h01);
        chk({7'h0, |tec}, 8'h00);
        rdc(ST, 8'h0c);
        $display("bus-off test done");
    endtask
    task automatic t_sleep;
        rdc(EV, 8'h04);
        apb(1'b1, CM, 8'h10);
        @(negedge clk);
        chk({7'h0, slp}, 8'h01);
        u_node.frame(8'h25);
        @(negedge clk);
        chk({7'h0, slp}, 8'h00);
        rdc(EV, 8'h10);
        rdc(ST, 8'h0c);
        $display("sleep test done");
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_filter;
        t_overrun;
        t_tx;
        t_busoff;
        t_sleep;
        stop_test;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test;
    end
endmodule
